//--- inc/mip_tail_regs.svh
`ifndef MIP_TAIL_REGS_SVH
`define MIP_TAIL_REGS_SVH
// How it works
// - tail placement only for y_major_a surfaces with tiled_resource_mode set
// - levels below tail_first_level use ordinary layout, others the tail layout
// - tail origin is column w1, row h0 plus aligned heights 2..first-1
// - 64k tail is one tile, first level in slot log2 samples, slots 4-14 in sub-tile
// - table row is relative level plus log2 samples (64k) or plus four (4k)
// - 4k tail uses the sub-tile layout with slots renumbered from zero
// - slots 11-13 placement depends on element size, same in both forms
// - 128-bit element tail offsets for rows 0..14
// - 64-bit element tail offsets for rows 0..14
// - 32-bit element tail offsets for rows 0..14
// - 16-bit element tail offsets for rows 0..14
// - 8-bit element tail offsets for rows 0..14
// - tail byte column and row add tail base and slot offset
// - y_major_a standard tiling ignores descriptor alignments, uses fixed ones
// - 64k alignments 64/64, 128/64, 128/128, 256/128, 256/256 by element size
// - 4k alignments 16/16, 32/16, 32/32, 64/32, 64/64 by element size
// - sample slice 64k surfaces divide alignments by sample-count factors
// - outside the tail, byte column and row use the level offset

// register byte offsets
`define REG_CTRL_OFS 12'h000
`define REG_SIZE_OFS 12'h004
`define REG_PITCH_OFS 12'h008
`define REG_STATUS_OFS 12'h00c
// control field positions
`define CTRL_TILE_Y_BIT 0
`define CTRL_TRM_LSB 1
`define CTRL_BPE_LSB 3
`define CTRL_SMP_LSB 6
`define CTRL_MSS_BIT 9
`define CTRL_TFL_LSB 12
`define CTRL_DHA_LSB 16
`define CTRL_DVA_LSB 20
`define CTRL_MASK 32'h00ff_f3ff
// reset values
`define CTRL_RST 32'h0022_0000
`define SIZE_RST 32'h0000_0000
`define PITCH_RST 16'h0000
// fixed alignment bases, log2 at 8-bit elements
`define ALIGN_64K_LG2 4'h8
`define ALIGN_4K_LG2 4'h6
// sub-tile base row in the offset table
`define SUBTILE_ROW 5'h04
`define TAIL_LAST_ROW 5'h0e
`endif

//--- inc/mip_tail_pkg.sv
package mip_tail_pkg;
  typedef enum logic [1:0] {no_tiled_resource, tile_4k_std, tile_64k_std} tiled_resource_mode_t;
  typedef enum logic [2:0] {bpe_8, bpe_16, bpe_32, bpe_64, bpe_128} bpe_t;
  typedef logic [3:0] lg2_t;
endpackage

//--- design/mip_tail_slot_lut.sv
`timescale 1ns/1ps
module mip_tail_slot_lut (
  input wire logic [2:0] bpe,
  input wire logic [3:0] row,
  output logic [7:0] mu,
  output logic [7:0] mv
);
  logic [79:0] pairs;

  // one word per row, pairs ordered 128,64,32,16,8 bits from the top
  // offset tables
  // slots 11-13 differ per element size
  always_comb begin
    unique case (row)
      4'h0: pairs = {8'h20, 8'h00, 8'h40, 8'h00, 8'h40, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00};
      4'h1: pairs = {8'h00, 8'h20, 8'h00, 8'h20, 8'h00, 8'h40, 8'h00, 8'h40, 8'h00, 8'h80};
      4'h2: pairs = {8'h10, 8'h00, 8'h20, 8'h00, 8'h20, 8'h00, 8'h40, 8'h00, 8'h40, 8'h00};
      4'h3: pairs = {8'h00, 8'h10, 8'h00, 8'h10, 8'h00, 8'h20, 8'h00, 8'h20, 8'h00, 8'h40};
      4'h4: pairs = {8'h08, 8'h00, 8'h10, 8'h00, 8'h10, 8'h00, 8'h20, 8'h00, 8'h20, 8'h00};
      4'h5: pairs = {8'h04, 8'h08, 8'h08, 8'h08, 8'h08, 8'h10, 8'h10, 8'h10, 8'h10, 8'h20};
      4'h6: pairs = {8'h00, 8'h0c, 8'h00, 8'h0c, 8'h00, 8'h18, 8'h00, 8'h18, 8'h00, 8'h30};
      4'h7: pairs = {8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h10, 8'h00, 8'h10, 8'h00, 8'h20};
      4'h8: pairs = {8'h04, 8'h04, 8'h08, 8'h04, 8'h08, 8'h08, 8'h10, 8'h08, 8'h10, 8'h10};
      4'h9: pairs = {8'h04, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h10, 8'h00, 8'h10, 8'h00};
      4'ha: pairs = {8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h10};
      4'hb: pairs = {8'h03, 8'h00, 8'h06, 8'h00, 8'h04, 8'h04, 8'h08, 8'h04, 8'h00, 8'h0c};
      4'hc: pairs = {8'h02, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h08, 8'h00, 8'h00, 8'h08};
      4'hd: pairs = {8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h04};
      default: pairs = 80'h0; // row 14 and beyond sit at the corner
    endcase
  end

  // pick the pair of this element size, 8-bit elements in the low bits
  always_comb begin
    mu = 8'h00;
    mv = 8'h00;
    if (bpe <= 3'h4) begin
      mu = pairs[{bpe, 4'h0} + 7'd8 +: 8];
      mv = pairs[{bpe, 4'h0} +: 8];
    end
  end
endmodule

//--- design/mip_tail_offset_calc.sv
`timescale 1ns/1ps
`include "mip_tail_regs.svh"
module mip_tail_offset_calc (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire logic [3:0] req_level,
  input wire logic [13:0] req_u,
  input wire logic [13:0] req_v,
  input wire logic [10:0] req_r,
  output logic out_valid,
  output logic [20:0] out_byte_col,
  output logic [27:0] out_row,
  output logic [3:0] out_halign_lg2,
  output logic [3:0] out_valign_lg2,
  output logic out_in_tail,
  output logic [3:0] out_slot,
  output logic out_slot_err
);
  logic [31:0] ctrl_ff;
  logic [31:0] size_ff;
  logic [15:0] pitch_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;
  logic bus_setup;
  logic bus_access;
  logic out_valid_ff;
  logic [20:0] byte_col_ff;
  logic [27:0] row_ff;
  logic [3:0] ha_ff;
  logic [3:0] va_ff;
  logic in_tail_ff;
  logic [3:0] slot_ff;
  logic slot_err_ff;

  // descriptor fields
  logic tile_y;
  mip_tail_pkg::tiled_resource_mode_t trm;
  logic [2:0] bpe;
  logic [2:0] smp;
  logic mss;
  logic [3:0] tfl;
  logic [15:0] width;
  logic [15:0] height;
  logic tail_en;
  logic is_64k;
  mip_tail_pkg::lg2_t ha;
  mip_tail_pkg::lg2_t va;

  // request datapath
  logic [15:0] w1;
  logic [15:0] h0;
  logic [19:0] tail_row_base;
  logic [19:0] lvl_row_base;
  logic nxt_in_tail;
  logic [3:0] rel;
  logic [4:0] tab_row;
  logic [3:0] nxt_slot;
  logic nxt_slot_err;
  logic [7:0] mu;
  logic [7:0] mv;
  logic [16:0] col_sum;
  logic [19:0] base_row;
  logic [20:0] nxt_byte_col;
  logic [27:0] nxt_row;

  // lower-resolution dimension of a level, never below one texel
  function automatic logic [15:0] dim_at(input logic [15:0] d, input logic [3:0] l);
    logic [15:0] s;
    s = d >> l;
    if (s == 16'h0) begin
      s = 16'h1;
    end
    return s;
  endfunction

  // round up to a power-of-two alignment
  function automatic logic [15:0] align_up(input logic [15:0] v, input logic [3:0] lg);
    logic [16:0] m;
    logic [16:0] s;
    m = (17'h1 << lg) - 17'h1;
    s = ({1'b0, v} + m) & ~m;
    return s[15:0];
  endfunction

  // h0 plus aligned heights of levels 2 up to n-1
  function automatic logic [19:0] level_row(input logic [15:0] ht, input logic [3:0] lg,
                                            input logic [3:0] n);
    logic [19:0] acc;
    acc = {4'h0, align_up(dim_at(ht, 4'h0), lg)};
    for (int i = 2; i < 15; i++) begin
      if (i < n) begin
        acc = acc + {4'h0, align_up(dim_at(ht, 4'(i)), lg)};
      end
    end
    return acc;
  endfunction

  // field extraction from the descriptor registers
  assign tile_y = ctrl_ff[`CTRL_TILE_Y_BIT];
  assign trm = mip_tail_pkg::tiled_resource_mode_t'(ctrl_ff[`CTRL_TRM_LSB +: 2]);
  assign bpe = (ctrl_ff[`CTRL_BPE_LSB +: 3] > 3'h4) ? 3'h4 : ctrl_ff[`CTRL_BPE_LSB +: 3];
  assign smp = (ctrl_ff[`CTRL_SMP_LSB +: 3] > 3'h4) ? 3'h4 : ctrl_ff[`CTRL_SMP_LSB +: 3];
  assign mss = ctrl_ff[`CTRL_MSS_BIT];
  assign tfl = ctrl_ff[`CTRL_TFL_LSB +: 4];
  assign width = size_ff[15:0];
  assign height = size_ff[31:16];
  assign is_64k = (trm == mip_tail_pkg::tile_64k_std);

  // tail only on y-major standard-tiled surfaces
  assign tail_en = tile_y && (trm != mip_tail_pkg::no_tiled_resource);

  // alignment selection, log2 form
  always_comb begin
    ha = ctrl_ff[`CTRL_DHA_LSB +: 4];
    va = ctrl_ff[`CTRL_DVA_LSB +: 4];
    if (tail_en) begin
      // base per tile size, less one step per two sizes
      ha = (is_64k ? `ALIGN_64K_LG2 : `ALIGN_4K_LG2) - {2'b00, bpe[2:1]};
      va = (is_64k ? `ALIGN_64K_LG2 : `ALIGN_4K_LG2) - 4'({1'b0, bpe} + 4'h1 >> 1);
      if (is_64k && mss) begin
        ha = ha - 4'({1'b0, smp} + 4'h1 >> 1);
        va = va - {2'b00, smp[2:1]};
      end
    end
  end

  // level geometry
  assign w1 = align_up(dim_at(width, 4'h1), ha);
  assign h0 = align_up(dim_at(height, 4'h0), va);
  assign tail_row_base = level_row(height, va, tfl);
  assign lvl_row_base = level_row(height, va, req_level);

  assign nxt_in_tail = tail_en && (req_level >= tfl);
  assign rel = req_level - tfl;

  // table row and slot number
  always_comb begin
    // row from relative level plus samples (64k) or plus the sub-tile row (4k)
    if (is_64k) begin
      tab_row = {1'b0, rel} + {2'b00, smp};
    end else begin
      tab_row = {1'b0, rel} + `SUBTILE_ROW;
    end
    // 64k slots follow the table row
    nxt_slot = is_64k ? tab_row[3:0] : rel;
    nxt_slot_err = nxt_in_tail && (tab_row > `TAIL_LAST_ROW);
  end

  // one table serves both tail forms
  mip_tail_slot_lut u_lut (
    .bpe(bpe),
    .row(nxt_slot_err ? 4'hf : tab_row[3:0]),
    .mu(mu),
    .mv(mv)
  );

  // level origin, tail or ordinary
  always_comb begin
    col_sum = 17'h0;
    base_row = 20'h0;
    if (nxt_in_tail) begin
      col_sum = {1'b0, w1} + {9'h0, mu};
      base_row = tail_row_base + {12'h0, mv};
    end else if (req_level == 4'h1) begin
      base_row = {4'h0, h0};
    end else if (req_level != 4'h0) begin
      col_sum = {1'b0, w1};
      base_row = lvl_row_base;
    end
  end

  // byte column scaled by bytes per texel, row from slice pitch, base and v unscaled
  always_comb begin
    nxt_byte_col = 21'((col_sum + {3'h0, req_u}) << bpe);
    nxt_row = 28'(req_r * pitch_ff) + {8'h0, base_row} + {14'h0, req_v};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid_ff <= 1'b0;
      byte_col_ff <= 21'h0;
      row_ff <= 28'h0;
      ha_ff <= 4'h0;
      va_ff <= 4'h0;
      in_tail_ff <= 1'b0;
      slot_ff <= 4'h0;
      slot_err_ff <= 1'b0;
    end else begin
      out_valid_ff <= req_valid;
      if (req_valid) begin
        byte_col_ff <= nxt_byte_col;
        row_ff <= nxt_row;
        ha_ff <= ha;
        va_ff <= va;
        in_tail_ff <= nxt_in_tail;
        slot_ff <= nxt_in_tail ? nxt_slot : 4'h0;
        slot_err_ff <= nxt_slot_err;
      end
    end
  end

  assign out_valid = out_valid_ff;
  assign out_byte_col = byte_col_ff;
  assign out_row = row_ff;
  assign out_halign_lg2 = ha_ff;
  assign out_valign_lg2 = va_ff;
  assign out_in_tail = in_tail_ff;
  assign out_slot = slot_ff;
  assign out_slot_err = slot_err_ff;

  // bus phases; one wait-free access cycle
  assign bus_setup = psel && !penable;
  assign bus_access = psel && penable && pready_ff;

  // read mux and unmapped decode, taken in the setup cycle
  always_comb begin
    nxt_prdata = 32'h0;
    nxt_pslverr = 1'b0;
    unique case (paddr)
      `REG_CTRL_OFS: nxt_prdata = ctrl_ff;
      `REG_SIZE_OFS: nxt_prdata = size_ff;
      `REG_PITCH_OFS: nxt_prdata = {16'h0, pitch_ff};
      `REG_STATUS_OFS: begin
        nxt_prdata = {14'h0, slot_err_ff, in_tail_ff, slot_ff, va, ha, 3'h0, tail_en};
        nxt_pslverr = pwrite; // status is read only
      end
      default: nxt_pslverr = 1'b1;
    endcase
  end

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= bus_setup;
      pslverr_ff <= bus_setup && nxt_pslverr;
      if (bus_setup && !pwrite) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // descriptor register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `CTRL_RST;
      size_ff <= `SIZE_RST;
      pitch_ff <= `PITCH_RST;
    end else if (bus_access && pwrite) begin
      if (paddr == `REG_CTRL_OFS) begin
        ctrl_ff <= pwdata & `CTRL_MASK;
      end
      if (paddr == `REG_SIZE_OFS) begin
        size_ff <= pwdata;
      end
      if (paddr == `REG_PITCH_OFS) begin
        pitch_ff <= pwdata[15:0];
      end
    end
  end

  // checks on the registered results
  a_valid_latency:
  assert property (@(posedge pclk) disable iff (!presetn)
    req_valid |=> out_valid && $past(req_valid))
    else $error("result not valid one clock after request");

  a_tail_needs_std:
  assert property (@(posedge pclk) disable iff (!presetn)
    out_valid && out_in_tail |-> $past(tile_y) && $past(trm) != mip_tail_pkg::no_tiled_resource)
    else $error("tail used on a surface without standard tiling");

  a_below_first:
  assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && (req_level < tfl) |=> !out_in_tail)
    else $error("level below tail start placed in tail");

  a_align_64k_wide:
  assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && tail_en && is_64k && !mss && bpe == 3'h4 |=> out_halign_lg2 == 4'h6
      && out_valign_lg2 == 4'h6)
    else $error("64k alignment at 128-bit elements wrong");

  a_align_4k_narrow:
  assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && tail_en && !is_64k && bpe == 3'h3 |=> out_halign_lg2 == 4'h5
      && out_valign_lg2 == 4'h4)
    else $error("4k alignment at 64-bit elements wrong");

  a_mss_divide:
  assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && tail_en && is_64k && mss && smp == 3'h3 && bpe == 3'h0
      |=> out_halign_lg2 == 4'h6 && out_valign_lg2 == 4'h7)
    else $error("sample slice alignment divisor wrong");

  a_slot_4k:
  assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && nxt_in_tail && !is_64k |=> out_slot == $past(req_level) - $past(tfl))
    else $error("4k tail slot not counted from zero");

  a_col_scale:
  assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && bpe == 3'h4 |=> out_byte_col[3:0] == 4'h0)
    else $error("byte column not scaled by texel size");

  a_level0_row:
  assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && !nxt_in_tail && req_level == 4'h0
      |=> out_row == 28'($past(req_r) * $past(pitch_ff)) + {14'h0, $past(req_v)})
    else $error("level zero row wrong");

  a_bus_one_wait:
  assert property (@(posedge pclk) disable iff (!presetn)
    bus_setup |=> pready ##1 !pready)
    else $error("bus answer not one cycle after setup");
endmodule

//--- dv/req_source.sv
`timescale 1ns/1ps
// address-generation stand-in: issues one request, captures the answer
module req_source (
  input wire logic pclk,
  output logic req_valid,
  output logic [3:0] req_level,
  output logic [13:0] req_u,
  output logic [13:0] req_v,
  output logic [10:0] req_r,
  input wire logic out_valid,
  input wire logic [20:0] out_byte_col,
  input wire logic [27:0] out_row,
  input wire logic out_in_tail,
  input wire logic [3:0] out_slot
);
  logic got_vld;
  logic got_tail;
  logic [20:0] got_col;
  logic [27:0] got_row;
  logic [3:0] got_slot;

  // idle request lines at time zero
  initial begin
    req_valid = 1'b0;
    req_level = 4'h0;
    req_u = 14'h0000;
    req_v = 14'h0000;
    req_r = 11'h000;
  end

  // one-cycle strobe, fields inverted once released, answer read next clock
  task automatic issue(input logic [3:0] lvl, input logic [13:0] u, input logic [13:0] v,
                       input logic [10:0] r);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_level <= lvl;
    req_u <= u;
    req_v <= v;
    req_r <= r;
    @(posedge pclk);
    req_valid <= 1'b0;
    req_level <= ~lvl;
    req_u <= ~u;
    req_v <= ~v;
    req_r <= ~r;
    #1;
    got_vld = out_valid;
    got_col = out_byte_col;
    got_row = out_row;
    got_tail = out_in_tail;
    got_slot = out_slot;
  endtask
endmodule

//--- dv/mip_tail_offset_calc_tb.sv
`timescale 1ns/1ps
`include "mip_tail_regs.svh"
module mip_tail_offset_calc_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic req_valid, out_valid, out_in_tail, out_slot_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] req_level, out_halign_lg2, out_valign_lg2, out_slot;
  logic [13:0] req_u, req_v;
  logic [10:0] req_r;
  logic [20:0] out_byte_col;
  logic [27:0] out_row;
  int fail_count, samples_checked, b, k, h, v;
  // tail offsets in texels, element size 8b..128b, rows 0..14
  int tu [5][15] = '{'{128,0,64,0,32,16,0,0,16,16,0,0,0,0,0},
    '{128,0,64,0,32,16,0,0,16,16,0,8,8,0,0}, '{64,0,32,0,16,8,0,0,8,8,0,4,4,0,0},
    '{64,0,32,0,16,8,0,0,8,8,0,6,4,2,0}, '{32,0,16,0,8,4,0,0,4,4,0,3,2,1,0}};
  int tv [5][15] = '{'{0,128,0,64,0,32,48,32,16,0,16,12,8,4,0},
    '{0,64,0,32,0,16,24,16,8,0,8,4,0,4,0}, '{0,64,0,32,0,16,24,16,8,0,8,4,0,4,0},
    '{0,32,0,16,0,8,12,8,4,0,4,0,0,0,0}, '{0,32,0,16,0,8,12,8,4,0,4,0,0,0,0}};

  mip_tail_offset_calc dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req_level(req_level), .req_u(req_u),
    .req_v(req_v), .req_r(req_r), .out_valid(out_valid), .out_byte_col(out_byte_col),
    .out_row(out_row), .out_halign_lg2(out_halign_lg2), .out_valign_lg2(out_valign_lg2),
    .out_in_tail(out_in_tail), .out_slot(out_slot), .out_slot_err(out_slot_err));

  req_source src_u (.pclk(pclk), .req_valid(req_valid), .req_level(req_level), .req_u(req_u),
    .req_v(req_v), .req_r(req_r), .out_valid(out_valid), .out_byte_col(out_byte_col),
    .out_row(out_row), .out_in_tail(out_in_tail), .out_slot(out_slot));

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // value aligned up to a power of two
  function automatic int alup(int x, int lg);
    return ((x + (1 << lg) - 1) >> lg) << lg;
  endfunction

  // log2 of fixed alignment: 64k or 4k, element size code, horizontal or vertical
  function automatic int alg(int big, int bc, int hz);
    return (big ? 8 : 6) - (hz ? bc / 2 : (bc + 1) / 2);
  endfunction

  // control word with y_major_a set
  function automatic logic [31:0] cw(int trm, int bc, int s, int mss, int tfl);
    return 32'(1 | (trm << 1) | (bc << 3) | (s << 6) | (mss << 9) | (tfl << 12));
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer, waits for pready; only the watchdog ends a stuck wait
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // program control, issue u=5 v=3 r=2, compare the answer
  task tr(input logic [31:0] c, input logic [3:0] lvl, input int ec, input int erow,
          input logic et, input logic [3:0] es);
    apb(1'b1, `REG_CTRL_OFS, c);
    src_u.issue(lvl, 14'h0005, 14'h0003, 11'h002);
    chk(src_u.got_vld, 1);
    chk(src_u.got_col, ec);
    chk(src_u.got_row, erow);
    chk(src_u.got_tail, et);
    chk(src_u.got_slot, es);
  endtask

  task summarize();
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    summarize();
  end

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    fail_count = 0;
    samples_checked = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `REG_CTRL_OFS, 32'h0);
    chk(rd, `CTRL_RST);
    apb(1'b0, `REG_SIZE_OFS, 32'h0);
    chk(rd, `SIZE_RST);
    apb(1'b0, `REG_PITCH_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `REG_CTRL_OFS, 32'hffff_ffff);
    apb(1'b0, `REG_CTRL_OFS, 32'h0);
    chk(rd, `CTRL_MASK);
    apb(1'b0, 12'h010, 32'h0);
    chk(er, 1);
    chk(rd, 32'h0);
    apb(1'b1, `REG_STATUS_OFS, 32'hffff_ffff);
    chk(er, 1);
    for (k = 1; k < 3; k++) begin
      for (b = 0; b < 5; b++) begin
        apb(1'b1, `REG_CTRL_OFS, cw(k, b, 0, 0, 0) | 32'h0053_0000);
        apb(1'b0, `REG_STATUS_OFS, 32'h0);
        chk(rd[11:4], {4'(alg(k == 2, b, 0)), 4'(alg(k == 2, b, 1))});
        chk(rd[0], 1);
      end
    end
    for (k = 1; k < 5; k++) begin
      apb(1'b1, `REG_CTRL_OFS, cw(2, 2, k, 1, 0));
      apb(1'b0, `REG_STATUS_OFS, 32'h0);
      chk(rd[11:4], {4'(7 - k / 2), 4'(7 - (k + 1) / 2)});
    end
    apb(1'b1, `REG_CTRL_OFS, 32'h0053_0004);
    apb(1'b0, `REG_STATUS_OFS, 32'h0);
    chk(rd[11:0], 12'h530);
    apb(1'b1, `REG_SIZE_OFS, 32'h0100_0100);
    apb(1'b1, `REG_PITCH_OFS, 32'h0000_0040);
    for (b = 0; b < 5; b++) begin
      h = alg(1, b, 1);
      v = alg(1, b, 0);
      for (k = 0; k < 15; k++) begin
        tr(cw(2, b, k == 14, 0, 2), 4'(2 + k - (k == 14)), (5 + alup(128, h) + tu[b][k]) << b,
           131 + alup(256, v) + tv[b][k], 1'b1, 4'(k));
        chk({out_slot_err, out_valign_lg2, out_halign_lg2}, {1'b0, 4'(v), 4'(h)});
      end
    end
    tr(cw(1, 2, 0, 0, 2), 4'h3, 564, 403, 1'b1, 4'h1);
    tr(cw(1, 3, 0, 0, 2), 4'h3, 1128, 395, 1'b1, 4'h1);
    chk({out_valign_lg2, out_halign_lg2}, 8'h45);
    tr(cw(2, 0, 3, 1, 2), 4'h2, 133, 451, 1'b1, 4'h3);
    chk({out_valign_lg2, out_halign_lg2}, 8'h76);
    tr(cw(2, 2, 4, 0, 2), 4'hd, 532, 387, 1'b1, 4'hf);
    chk(out_slot_err, 1'b1);
    apb(1'b0, `REG_STATUS_OFS, 32'h0);
    chk(rd[17:12], 6'h3f);
    tr(cw(2, 2, 0, 0, 4), 4'h4, 788, 643, 1'b1, 4'h0);
    tr(cw(2, 2, 0, 0, 4), 4'h3, 532, 515, 1'b0, 4'h0);
    tr(cw(2, 2, 0, 0, 4), 4'h0, 20, 131, 1'b0, 4'h0);
    tr(cw(2, 2, 0, 0, 4), 4'h1, 20, 387, 1'b0, 4'h0);
    tr(cw(0, 2, 0, 0, 2), 4'h5, 532, 499, 1'b0, 4'h0);
    tr(cw(2, 2, 0, 0, 2) & 32'hffff_fffe, 4'h5, 532, 499, 1'b0, 4'h0);
    summarize();
  end
endmodule
